// ---- rtl/satc_host.sv ----
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "satc_map.svh"

module satc_host
  import satc_pkg::*;
(
  // Link pins
  satc_if.host                     lnk,
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                ce,
  // APB slave
  input  wire logic [`SATC_ADDR_W-1:0] paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr
);

  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_CTRL = 2'h1;
  localparam logic [1:0] SEL_WORD = 2'h2;
  localparam logic [1:0] SEL_STAT = 2'h3;

  satc_mode_t  ctrl_mode;
  satc_word_t  word_reg;
  logic        go;
  satc_state_t state;
  satc_cnt_t   wait_cnt;
  satc_word_t  shifter;
  logic [2:0]  bits_left;
  satc_word_t  par_out;
  logic        sclk_q;
  logic        data_q;
  logic        strobe_q;
  logic        select_q;
  logic [1:0]  sel;
  logic        busy;
  logic        err;
  logic        acc;
  logic [31:0] rd_val;

  function automatic logic [1:0] reg_sel(
    input logic [`SATC_ADDR_W-1:0] addr);
    if (addr == `SATC_REG_CTRL) begin
      reg_sel = SEL_CTRL;
    end else if (addr == `SATC_REG_WORD) begin
      reg_sel = SEL_WORD;
    end else if (addr == `SATC_REG_STAT) begin
      reg_sel = SEL_STAT;
    end else begin
      reg_sel = SEL_NONE;
    end
  endfunction : reg_sel

  ////////////////////////////////////////////////////////////////////////
  // Bus decode
  assign sel    = reg_sel(paddr);
  assign busy   = (state != satc_st_idle) || go;
  assign err    = (sel == SEL_NONE) ||
                  (pwrite && (sel == SEL_STAT || busy)) ||
                  (pwrite && sel == SEL_CTRL &&
                   pwdata[1:0] == `SATC_MODE_BAD);
  assign acc    = psel && penable && pready && pwrite && !pslverr &&
                  reg_sel(paddr) != SEL_NONE;
  assign rd_val = (sel == SEL_CTRL) ? 32'(ctrl_mode) :
                  (sel == SEL_WORD) ? 32'(word_reg)  :
                  (sel == SEL_STAT) ? 32'(busy)      : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        pslverr <= err;
        prdata  <= pwrite ? 32'h0000_0000 : rd_val;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_mode <= satc_mode_serial;
      word_reg  <= `SATC_ATT_MAX;
      go        <= 1'b0;
    end else if (ce) begin
      go <= 1'b0;
      if (acc && sel == SEL_CTRL) begin
        ctrl_mode <= satc_mode_t'(pwdata[1:0]);
      end
      if (acc && sel == SEL_WORD) begin
        word_reg <= pwdata[`SATC_WORD_W-1:0];
        go       <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= satc_st_idle;
      wait_cnt  <= '0;
      shifter   <= '0;
      bits_left <= '0;
      par_out   <= '0;
      sclk_q    <= 1'b0;
      data_q    <= 1'b0;
      strobe_q  <= 1'b0;
      select_q  <= 1'b1;
    end else if (ce) begin
      case (state)
        satc_st_idle: begin
          select_q <= (ctrl_mode == satc_mode_serial);
          strobe_q <= (ctrl_mode == satc_mode_direct);
          if (ctrl_mode == satc_mode_serial) begin
            par_out <= '0;
          end
          if (go) begin
            case (ctrl_mode)
              satc_mode_serial: begin
                shifter   <= word_reg;
                data_q    <= word_reg[`SATC_ATT_MSB];
                bits_left <= 3'(`SATC_WORD_W);
                wait_cnt  <= satc_cnt_t'(`SATC_SCLK_HALF_CYC);
                state     <= satc_st_clk_lo;
              end
              satc_mode_direct: begin
                par_out  <= word_reg;
                wait_cnt <= satc_cnt_t'(`SATC_SETTLE_MAX_CYC);
                state    <= satc_st_settle;
              end
              default: begin
                par_out  <= word_reg;
                wait_cnt <= satc_cnt_t'(`SATC_PAR_SETUP_CYC);
                state    <= satc_st_setup;
              end
            endcase
          end
        end
        satc_st_setup: begin
          if (wait_cnt == 8'h01) begin
            strobe_q <= 1'b1;
            wait_cnt <= satc_cnt_t'(`SATC_STROBE_CYC);
            state    <= satc_st_strobe;
          end else begin
            wait_cnt <= wait_cnt - 1'b1;
          end
        end
        satc_st_clk_lo: begin
          if (wait_cnt == 8'h01) begin
            sclk_q   <= 1'b1;
            wait_cnt <= satc_cnt_t'(`SATC_SCLK_HALF_CYC);
            state    <= satc_st_clk_hi;
          end else begin
            wait_cnt <= wait_cnt - 1'b1;
          end
        end
        satc_st_clk_hi: begin
          if (wait_cnt == 8'h01) begin
            sclk_q <= 1'b0;
            if (bits_left == 3'h1) begin
              strobe_q <= 1'b1;
              wait_cnt <= satc_cnt_t'(`SATC_STROBE_CYC);
              state    <= satc_st_strobe;
            end else begin
              shifter   <= shifter << 1;
              data_q    <= shifter[`SATC_ATT_MSB-1];
              bits_left <= bits_left - 1'b1;
              wait_cnt  <= satc_cnt_t'(`SATC_SCLK_HALF_CYC);
              state     <= satc_st_clk_lo;
            end
          end else begin
            wait_cnt <= wait_cnt - 1'b1;
          end
        end
        satc_st_strobe: begin
          if (wait_cnt == 8'h01) begin
            strobe_q <= 1'b0;
            wait_cnt <= satc_cnt_t'(`SATC_SETTLE_MAX_CYC);
            state    <= satc_st_settle;
          end else begin
            wait_cnt <= wait_cnt - 1'b1;
          end
        end
        satc_st_settle: begin
          if (wait_cnt == 8'h01) begin
            state <= satc_st_idle;
          end else begin
            wait_cnt <= wait_cnt - 1'b1;
          end
        end
        default: begin
          state <= satc_st_idle;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drive
  assign lnk.sclk                 = sclk_q;
  assign lnk.serial_data_in       = data_q;
  assign lnk.latch_strobe         = strobe_q;
  assign lnk.serial_select        = select_q;
  assign lnk.atten_bit_half_db    = par_out[0];
  assign lnk.atten_bit_one_db     = par_out[1];
  assign lnk.atten_bit_two_db     = par_out[2];
  assign lnk.atten_bit_four_db    = par_out[3];
  assign lnk.atten_bit_eight_db   = par_out[4];
  assign lnk.atten_bit_sixteen_db = par_out[5];

endmodule : satc_host

`default_nettype wire

// ---- rtl/satc_map.svh ----
`ifndef SATC_MAP_SVH
`define SATC_MAP_SVH

////////////////////////////////////////////////////////////////////////
// Word layout and power-up value
`define SATC_WORD_W        6
`define SATC_ATT_MSB       5
`define SATC_ATT_MAX       6'h3f
`define SATC_TENTHS_MAX    9'h13b
`define SATC_HALF_DB_TENTHS 5

////////////////////////////////////////////////////////////////////////
// Synchroniser bit positions
`define SATC_PIN_N         8
`define SATC_PIN_STROBE    6
`define SATC_PIN_SELECT    7

////////////////////////////////////////////////////////////////////////
// Timing, in ns and in pclk cycles
`define SATC_PCLK_NS       8
`define SATC_SCLK_MIN_NS   100
`define SATC_SCLK_HALF_CYC \
  ((`SATC_SCLK_MIN_NS + 2 * `SATC_PCLK_NS - 1) / (2 * `SATC_PCLK_NS))
`define SATC_STROBE_NS     30
`define SATC_STROBE_CYC \
  ((`SATC_STROBE_NS + `SATC_PCLK_NS - 1) / `SATC_PCLK_NS)
`define SATC_PAR_SETUP_NS  10
`define SATC_PAR_SETUP_CYC \
  ((`SATC_PAR_SETUP_NS + `SATC_PCLK_NS - 1) / `SATC_PCLK_NS)
`define SATC_SETTLE_TYP_NS 500
`define SATC_SETTLE_TYP_CYC (`SATC_SETTLE_TYP_NS / `SATC_PCLK_NS)
`define SATC_SETTLE_MAX_NS 800
`define SATC_SETTLE_MAX_CYC (`SATC_SETTLE_MAX_NS / `SATC_PCLK_NS)

////////////////////////////////////////////////////////////////////////
// Controller register map
`define SATC_ADDR_W        12
`define SATC_REG_CTRL      12'h000
`define SATC_REG_WORD      12'h004
`define SATC_REG_STAT      12'h008
`define SATC_MODE_BAD      2'h3

`endif

// ---- rtl/satc_pkg.sv ----
`include "satc_map.svh"

package satc_pkg;

  typedef logic [`SATC_WORD_W-1:0] satc_word_t;
  typedef logic [7:0]              satc_cnt_t;
  typedef logic [8:0]              satc_tenths_t;

  typedef enum logic [1:0] {
    satc_mode_serial,
    satc_mode_direct,
    satc_mode_latched
  } satc_mode_t;

  typedef enum logic [2:0] {
    satc_st_idle,
    satc_st_setup,
    satc_st_clk_lo,
    satc_st_clk_hi,
    satc_st_strobe,
    satc_st_settle
  } satc_state_t;

  // Attenuation in tenths of a dB
  function automatic satc_tenths_t satc_tenths(input satc_word_t word);
    satc_tenths_t sum;
    sum = '0;
    for (int i = 0; i < `SATC_WORD_W; i++) begin
      if (word[i]) begin
        sum = sum + (satc_tenths_t'(`SATC_HALF_DB_TENTHS) << i);
      end
    end
    return sum;
  endfunction : satc_tenths

endpackage : satc_pkg

// ---- rtl/satc_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface satc_if;

  logic sclk;
  logic serial_data_in;
  logic latch_strobe;
  logic serial_select;
  logic atten_bit_half_db;
  logic atten_bit_one_db;
  logic atten_bit_two_db;
  logic atten_bit_four_db;
  logic atten_bit_eight_db;
  logic atten_bit_sixteen_db;

  modport device (
    input sclk,
    input serial_data_in,
    input latch_strobe,
    input serial_select,
    input atten_bit_half_db,
    input atten_bit_one_db,
    input atten_bit_two_db,
    input atten_bit_four_db,
    input atten_bit_eight_db,
    input atten_bit_sixteen_db
  );

  modport host (
    output sclk,
    output serial_data_in,
    output latch_strobe,
    output serial_select,
    output atten_bit_half_db,
    output atten_bit_one_db,
    output atten_bit_two_db,
    output atten_bit_four_db,
    output atten_bit_eight_db,
    output atten_bit_sixteen_db
  );

endinterface : satc_if

`default_nettype wire

// ---- rtl/satc_device.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "satc_map.svh"

////////////////////////////////////////////////////////////////////////
// Function
// - Select input picks parallel or serial path
// - Six-bit shift register, MSB shifted first
// - Data sampled on rising serial clock
// - Strobe rise transfers shift word to setting
// - Strobe high masks serial clock edges
// - Power-up holds maximum attenuation until programmed
// - Bits weigh half dB through sixteen dB
// - Setting is sum of asserted bit weights
// - Host grounds parallel inputs in serial mode
// - Serial clock period at least 100 ns
// - Strobe pulse 30 ns, spaced 600 ns
// - New setting settles within 800 ns
// - Direct parallel: strobe high, inputs followed
// - Latched parallel: strobe fall captures inputs
module satc_device
  import satc_pkg::*;
(
  // Link pins
  satc_if.device             lnk,
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          ce,
  // Attenuator state
  output var satc_word_t     attenuation_setting,
  output var satc_tenths_t   atten_tenths_db,
  output logic               rf_settling,
  output logic               rf_typ_settled,
  output logic               update_pulse,
  output logic               programmed,
  output var satc_mode_t     update_src
);

  logic [`SATC_PIN_N-1:0] pin_raw;
  logic [`SATC_PIN_N-1:0] pin_sync;
  satc_word_t             shift_word;
  satc_word_t             par_word;
  satc_word_t             par_prev;
  logic                   serial_mode;
  logic                   strobe_now;
  logic                   strobe_prev;
  logic                   strobe_rise;
  logic                   strobe_fall;
  satc_word_t             next_setting;
  satc_mode_t             next_src;
  logic                   next_load;
  logic                   change;
  satc_cnt_t              settle_max_cnt;
  satc_cnt_t              settle_typ_cnt;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  assign pin_raw = {
    lnk.serial_select,
    lnk.latch_strobe,
    lnk.atten_bit_sixteen_db,
    lnk.atten_bit_eight_db,
    lnk.atten_bit_four_db,
    lnk.atten_bit_two_db,
    lnk.atten_bit_one_db,
    lnk.atten_bit_half_db
  };

  generate
    for (genvar i = 0; i < `SATC_PIN_N; i++) begin : g_sync
      logic meta;
      logic held;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta <= 1'b0;
          held <= 1'b0;
        end else if (ce) begin
          meta <= pin_raw[i];
          held <= meta;
        end
      end
      assign pin_sync[i] = held;
    end
  endgenerate

  assign serial_mode = pin_sync[`SATC_PIN_SELECT];
  assign strobe_now  = pin_sync[`SATC_PIN_STROBE];
  assign par_word    = pin_sync[`SATC_WORD_W-1:0];

  ////////////////////////////////////////////////////////////////////////
  // Serial shift register on the link clock
  always_ff @(posedge lnk.sclk or negedge presetn) begin
    if (!presetn) begin
      shift_word <= `SATC_ATT_MAX;
    end else if (lnk.serial_select && !lnk.latch_strobe) begin
      shift_word <= {shift_word[`SATC_ATT_MSB-1:0],
                     lnk.serial_data_in};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Strobe edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_prev <= 1'b0;
      par_prev    <= '0;
    end else if (ce) begin
      strobe_prev <= strobe_now;
      par_prev    <= par_word;
    end
  end

  assign strobe_rise = strobe_now && !strobe_prev;
  assign strobe_fall = !strobe_now && strobe_prev;

  ////////////////////////////////////////////////////////////////////////
  // Next setting
  always_comb begin
    next_setting = attenuation_setting;
    next_src     = update_src;
    next_load    = 1'b0;
    if (serial_mode) begin
      if (strobe_rise) begin
        // Shift word is frozen while the strobe is high
        next_setting = shift_word;
        next_src     = satc_mode_serial;
        next_load    = 1'b1;
      end
    end else if (strobe_now) begin
      next_setting = par_word;
      next_src     = satc_mode_direct;
      next_load    = 1'b1;
    end else if (strobe_fall) begin
      next_setting = par_prev;
      next_src     = satc_mode_latched;
      next_load    = 1'b1;
    end
  end

  assign change = next_setting != attenuation_setting;

  ////////////////////////////////////////////////////////////////////////
  // Active setting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      attenuation_setting <= `SATC_ATT_MAX;
      atten_tenths_db     <= `SATC_TENTHS_MAX;
      update_src          <= satc_mode_serial;
      update_pulse        <= 1'b0;
    end else if (ce) begin
      attenuation_setting <= next_setting;
      atten_tenths_db     <= satc_tenths(next_setting);
      update_src          <= next_src;
      update_pulse        <= change;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // First word seen since power-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      programmed <= 1'b0;
    end else if (ce && next_load) begin
      programmed <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Settling timers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_max_cnt <= '0;
      rf_settling    <= 1'b0;
    end else if (ce) begin
      if (change) begin
        settle_max_cnt <= satc_cnt_t'(`SATC_SETTLE_MAX_CYC);
        rf_settling    <= 1'b1;
      end else if (settle_max_cnt != 8'h00) begin
        settle_max_cnt <= settle_max_cnt - 1'b1;
        if (settle_max_cnt == 8'h01) begin
          rf_settling <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_typ_cnt <= '0;
      rf_typ_settled <= 1'b1;
    end else if (ce) begin
      if (change) begin
        settle_typ_cnt <= satc_cnt_t'(`SATC_SETTLE_TYP_CYC);
        rf_typ_settled <= 1'b0;
      end else if (settle_typ_cnt != 8'h00) begin
        settle_typ_cnt <= settle_typ_cnt - 1'b1;
        if (settle_typ_cnt == 8'h01) begin
          rf_typ_settled <= 1'b1;
        end
      end
    end
  end

endmodule : satc_device

`default_nettype wire

// ---- sim/satc_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "satc_map.svh"

module satc_monitor
  import satc_pkg::*;
(
  // Clock and reset
  input wire logic         pclk,
  input wire logic         presetn,
  // Link pins
  input wire logic         sclk,
  input wire logic         serial_data_in,
  input wire logic         latch_strobe,
  input wire logic         serial_select,
  input wire logic         atten_bit_half_db,
  input wire logic         atten_bit_one_db,
  input wire logic         atten_bit_two_db,
  input wire logic         atten_bit_four_db,
  input wire logic         atten_bit_eight_db,
  input wire logic         atten_bit_sixteen_db,
  // Device state
  input wire satc_word_t   attenuation_setting,
  input wire satc_tenths_t atten_tenths_db,
  input wire logic         rf_settling,
  input wire logic         rf_typ_settled,
  input wire logic         update_pulse,
  input wire logic         programmed
);

  satc_cnt_t  settle_cnt;
  satc_cnt_t  typ_cnt;
  satc_word_t pins;

  assign pins = {atten_bit_sixteen_db, atten_bit_eight_db, atten_bit_four_db,
                 atten_bit_two_db, atten_bit_one_db, atten_bit_half_db};

  default clocking mon_cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////
  // Run lengths of the settle flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_cnt <= 8'h00;
    end else begin
      settle_cnt <= rf_settling ? settle_cnt + 8'h01 : 8'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      typ_cnt <= 8'h00;
    end else begin
      typ_cnt <= !rf_typ_settled ? typ_cnt + 8'h01 : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  sclk_parallel_a: assert property (!serial_select |-> !sclk)
    else $error("serial clock runs in parallel mode");
  sclk_masked_a: assert property (latch_strobe && serial_select |->
    !sclk) else $error("serial clock runs while strobe high");
  clk_high_a: assert property ($rose(sclk) |-> sclk[*7] ##1 !sclk)
    else $error("serial clock high time wrong");
  data_hold_a: assert property ($rose(sclk) |->
    $stable(serial_data_in) ##1 $stable(serial_data_in)[*6])
    else $error("serial data moves near clock rise");
  strobe_width_a: assert property ($rose(latch_strobe) &&
    serial_select |-> latch_strobe[*4] ##1 !latch_strobe)
    else $error("strobe pulse width wrong");
  load_delay_a: assert property ($rose(latch_strobe) &&
    serial_select |-> ##3 update_pulse)
    else $error("strobe did not load");
  settle_len_a: assert property ($fell(rf_settling) |->
    settle_cnt == 8'h64) else $error("settle window wrong");
  typ_len_a: assert property ($rose(rf_typ_settled) |->
    typ_cnt == 8'h3e) else $error("typical settle window wrong");
  powerup_max_a: assert property (!programmed |->
    attenuation_setting == `SATC_ATT_MAX)
    else $error("setting left maximum early");
  weight_sum_a: assert property (atten_tenths_db ==
    9'h005 * {3'h0, attenuation_setting})
    else $error("attenuation is not the weight sum");
  serial_quiet_a: assert property (serial_select && sclk |->
    pins == 6'h00) else $error("parallel pins driven in serial mode");

  cover property ($rose(latch_strobe) && serial_select);
  cover property ($fell(latch_strobe) && !serial_select);
  cover property ($rose(latch_strobe) && !serial_select);

endmodule : satc_monitor

`default_nettype wire

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "satc_map.svh"

module tb_top
  import satc_pkg::*;
;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata;
  satc_word_t   attenuation_setting, att_b, snoop, pins;
  satc_tenths_t atten_tenths_db;
  logic         rf_settling, rf_typ_settled, update_pulse, programmed;
  satc_mode_t   update_src;
  int           mismatches, samples_checked, nbits;

  satc_if lnk();
  satc_if lnk_b();

  satc_host satc_host_inst(.lnk(lnk), .pclk(pclk), .presetn(presetn),
    .ce(1'b1), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  satc_device satc_device_inst(.lnk(lnk), .pclk(pclk), .presetn(presetn),
    .ce(1'b1), .attenuation_setting(attenuation_setting),
    .atten_tenths_db(atten_tenths_db), .rf_settling(rf_settling),
    .rf_typ_settled(rf_typ_settled), .update_pulse(update_pulse),
    .programmed(programmed), .update_src(update_src));
  satc_device satc_device_fault_inst(.lnk(lnk_b), .pclk(pclk),
    .presetn(presetn), .ce(1'b1), .attenuation_setting(att_b),
    .atten_tenths_db(), .rf_settling(), .rf_typ_settled(),
    .update_pulse(), .programmed(), .update_src());
  satc_monitor satc_monitor_inst(.pclk(pclk), .presetn(presetn),
    .sclk(lnk.sclk), .serial_data_in(lnk.serial_data_in),
    .latch_strobe(lnk.latch_strobe), .serial_select(lnk.serial_select),
    .atten_bit_half_db(lnk.atten_bit_half_db),
    .atten_bit_one_db(lnk.atten_bit_one_db),
    .atten_bit_two_db(lnk.atten_bit_two_db),
    .atten_bit_four_db(lnk.atten_bit_four_db),
    .atten_bit_eight_db(lnk.atten_bit_eight_db),
    .atten_bit_sixteen_db(lnk.atten_bit_sixteen_db),
    .attenuation_setting(attenuation_setting),
    .atten_tenths_db(atten_tenths_db), .rf_settling(rf_settling),
    .rf_typ_settled(rf_typ_settled), .update_pulse(update_pulse),
    .programmed(programmed));

  assign pins = {lnk.atten_bit_sixteen_db, lnk.atten_bit_eight_db,
    lnk.atten_bit_four_db, lnk.atten_bit_two_db, lnk.atten_bit_one_db,
    lnk.atten_bit_half_db};

  ////////////////////////////////////////////////////////////////////////
  // Clock, wire snooper, watchdog
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  always @(posedge lnk.sclk) begin
    if (!lnk.latch_strobe) begin
      snoop <= {snoop[4:0], lnk.serial_data_in};
      nbits <= nbits + 1;
    end
  end

  initial begin
    repeat (60000) @(posedge pclk);
    mismatches++;
    $display("[FAIL] watchdog expired");
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////
  // Common tasks
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic exp_err);
    logic [31:0] rd;
    logic        err;
    apb(a, 1'b1, d, rd, err);
    chk("write error", 32'(exp_err), 32'(err));
  endtask : wr

  task automatic wait_idle();
    logic [31:0] rd;
    logic        err;
    int          n;
    n = 0;
    do begin
      apb(`SATC_REG_STAT, 1'b0, 32'h0, rd, err);
      n++;
    end while (rd[0] !== 1'b0 && n < 400);
    chk("busy", 32'h0, 32'(rd[0]));
  endtask : wait_idle

  task automatic wait_word(input satc_word_t w);
    int n;
    n = 0;
    while (!(update_pulse === 1'b1 && attenuation_setting === w) && n < 400)
    begin
      @(posedge pclk);
      n++;
    end
    chk("setting", 32'(w), 32'(attenuation_setting));
    chk("tenths", 32'(w) * 5, 32'(atten_tenths_db));
    chk("settling", 32'h1, 32'(rf_settling));
    chk("typical", 32'h0, 32'(rf_typ_settled));
    chk("programmed", 32'h1, 32'(programmed));
  endtask : wait_word

  task automatic load(input satc_mode_t m, input satc_word_t w);
    nbits = 0;
    wr(`SATC_REG_CTRL, {30'h0, m}, 1'b0);
    wr(`SATC_REG_WORD, {26'h0, w}, 1'b0);
    wait_word(w);
    chk("select", 32'(m == satc_mode_serial), 32'(lnk.serial_select));
    if (m == satc_mode_serial) begin
      chk("bit count", 32'h6, 32'(nbits));
      chk("shifted word", 32'(w), 32'(snoop));
    end else begin
      chk("pins", 32'(w), 32'(pins));
    end
    wait_idle();
    chk("source", 32'(m), 32'(update_src));
    chk("strobe", 32'(m==satc_mode_direct), 32'(lnk.latch_strobe));
    chk("sclk idle", 32'h0, 32'(lnk.sclk));
  endtask : load

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_powerup();
    @(posedge pclk);
    chk("reset setting", 32'h3f, 32'(attenuation_setting));
    chk("reset tenths", 32'h13b, 32'(atten_tenths_db));
    chk("reset programmed", 32'h0, 32'(programmed));
    chk("reset select", 32'h1, 32'(lnk.serial_select));
    $display("test powerup done");
  endtask : t_powerup

  task automatic t_serial();
    satc_word_t words[9] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08,
                             6'h10, 6'h20, 6'h3f, 6'h2a};
    foreach (words[i]) load(satc_mode_serial, words[i]);
    $display("test serial done");
  endtask : t_serial

  task automatic t_refuse();
    logic [31:0] rd;
    logic        err;
    apb(12'h00c, 1'b0, 32'h0, rd, err);
    chk("unmapped error", 32'h1, 32'(err));
    chk("unmapped data", 32'h0, rd);
    wr(`SATC_REG_STAT, 32'h1, 1'b1);
    wr(`SATC_REG_CTRL, 32'h3, 1'b1);
    wr(`SATC_REG_WORD, 32'h11, 1'b0);
    wr(`SATC_REG_WORD, 32'h22, 1'b1);
    wait_word(6'h11);
    wait_idle();
    $display("test refusals done");
  endtask : t_refuse

  task automatic t_parallel();
    load(satc_mode_latched, 6'h15);
    load(satc_mode_latched, 6'h2a);
    load(satc_mode_direct, 6'h33);
    load(satc_mode_direct, 6'h0c);
    $display("test parallel done");
  endtask : t_parallel

  task automatic pulse_b(input logic b);
    lnk_b.serial_data_in <= b;
    repeat (5) @(posedge pclk);
    lnk_b.sclk <= 1'b1;
    repeat (5) @(posedge pclk);
    lnk_b.sclk <= 1'b0;
  endtask : pulse_b

  task automatic strobe_b();
    repeat (2) @(posedge pclk);
    lnk_b.latch_strobe <= 1'b1;
    repeat (4) @(posedge pclk);
    lnk_b.latch_strobe <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask : strobe_b

  task automatic t_fault();
    logic [7:0] pat = 8'hd6;
    for (int i = 7; i >= 0; i--) pulse_b(pat[i]);
    strobe_b();
    chk("overlong word", 32'h16, 32'(att_b));
    repeat (2) @(posedge pclk);
    lnk_b.latch_strobe <= 1'b1;
    for (int i = 0; i < 6; i++) pulse_b(1'b1);
    lnk_b.latch_strobe <= 1'b0;
    strobe_b();
    chk("masked clocks", 32'h16, 32'(att_b));
    $display("test fault done");
  endtask : t_fault

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {lnk_b.sclk, lnk_b.serial_data_in, lnk_b.latch_strobe} = 3'h0;
    lnk_b.serial_select = 1'b1;
    {lnk_b.atten_bit_half_db, lnk_b.atten_bit_one_db,
     lnk_b.atten_bit_two_db, lnk_b.atten_bit_four_db,
     lnk_b.atten_bit_eight_db, lnk_b.atten_bit_sixteen_db} = 6'h00;
    snoop = 6'h00;
    nbits = 0;
    do_reset();
    t_powerup();
    t_serial();
    t_refuse();
    t_parallel();
    do_reset();
    t_powerup();
    t_fault();
    load(satc_mode_serial, 6'h07);
    stop_test();
  end

endmodule : tb_top

`default_nettype wire
